// ===== design/pmsec_bank.sv
// Manufacturer security and tuning command bank of a power controller.
// Assumes the PMBus layer gives one command byte, then data bytes, then a stop strobe.
// What this block does
// - Password setup write carries twelve bytes: six current, six new password.
// - Accepting a password setup with the correct current password turns security on.
// - Reading password setup returns zeros, never the stored password.
// - Correct disable-once password suspends protection until power reset.
// - Disable-once while security is off is refused with NACK.
// - 256-bit mask protects each command while security is on.
// - Debug buffer read returns eight bytes of internal debug contents.
// - Turn ratio holds primary turns high nibble, secondary turns low nibble.
// - Oscillator trim holds an unsigned eight-bit internal clock trim.
// - Exceeded capacitance limit scales rise time by its signed ramp factor.
// - Above third limit use third factor and loop coefficient bank 3.
// - Above second or first limit use the second or first factor.
// - Capacitance is measured between programmed ramp start and end voltages.
// - Soft start raises current limit by the programmed percentage.
`include "pmsec_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module pmsec_bank
  import pmsec_pkg::*;
(
  // Clock and reset.
  input  wire logic        CLOCK,
  input  wire logic        RESET_N,
  // Command stream from the PMBus layer.
  input  wire logic        CMD_VALID,
  input  wire logic [7:0]  CMD_CODE,
  input  wire logic        WR_VALID,
  input  wire logic [7:0]  WR_BYTE,
  input  wire logic        WR_STOP,
  input  wire logic        RD_REQ,
  input  wire logic [4:0]  RD_INDEX,
  output logic [7:0]       RD_BYTE,
  output logic             CMD_NACK,
  output logic             CMD_PROTECTED,
  // Converter side.
  input  wire logic [63:0] DEBUG_BUF,
  input  wire logic [7:0]  CAP_ESTIMATE,
  input  wire logic        CAP_VALID,
  input  wire logic [15:0] TON_RISE,
  input  wire logic [15:0] CURRENT_LIMIT_USER,
  input  wire logic        SOFT_START,
  output logic             SECURITY_ON,
  output logic [7:0]       TURNS,
  output logic [7:0]       OSC_TRIM,
  output logic [15:0]      RISE_TIME,
  output logic             COEF_BANK3,
  output logic [7:0]       MEAS_V_START,
  output logic [7:0]       MEAS_V_END,
  output logic [15:0]      CURRENT_LIMIT
);

  pmsec_state_t state_q;
  logic [7:0]   cmd_q;
  logic [5:0]   cnt_q;
  logic [255:0] buf_q;
  logic [47:0]  pw_q;
  logic         sec_q;
  logic         susp_q;
  logic [255:0] mask_q;
  pmsec_slc_t   slc_q;
  logic [7:0]   ssil_q;

  function automatic logic [15:0] scale_rise(input logic [15:0] t, input logic [7:0] k);
    logic signed [24:0] p;
    p = $signed({1'b0, t}) * $signed(k);
    scale_rise = (p < 0) ? 16'h0000 : p[15:0];
  endfunction : scale_rise

  // Protection decision for the command now opened.
  wire       prot_hit = sec_q && !susp_q && mask_q[CMD_CODE];
  wire       dis_off  = (CMD_CODE == `PMSEC_CMD_DISONCE) && !sec_q;
  wire       wr_byte  = (state_q == PMSEC_WR) && WR_VALID;
  wire [5:0] nbytes   = cnt_q;
  wire       stop_ok  = (state_q == PMSEC_WR) && WR_STOP;
  wire       pw_len   = nbytes[4:0] == `PMSEC_LEN_PWSETUP;
  wire [47:0] pw_cur  = buf_q[95:48];
  wire [47:0] pw_new  = buf_q[47:0];
  wire       pw_set   = stop_ok && cmd_q == `PMSEC_CMD_PWSETUP && pw_len && pw_cur == pw_q;
  wire       dis_do   = stop_ok && cmd_q == `PMSEC_CMD_DISONCE && sec_q
                        && nbytes[4:0] == `PMSEC_LEN_DISONCE && buf_q[47:0] == pw_q;
  wire       byte_wr  = stop_ok && nbytes[4:0] == `PMSEC_LEN_BYTE;
  wire       slc_wr   = stop_ok && cmd_q == `PMSEC_CMD_SLCCFG
                        && nbytes[4:0] == `PMSEC_LEN_SLCCFG;
  wire       mask_wr  = stop_ok && cmd_q == `PMSEC_CMD_MASK && nbytes == `PMSEC_LEN_MASK;

  // Highest exceeded limit wins; limits are signed values.
  wire over3 = CAP_VALID && $signed(CAP_ESTIMATE) > $signed(slc_q.limit3);
  wire over2 = CAP_VALID && $signed(CAP_ESTIMATE) > $signed(slc_q.limit2);
  wire over1 = CAP_VALID && $signed(CAP_ESTIMATE) > $signed(slc_q.limit1);
  wire [15:0] rise_d = over3 ? scale_rise(TON_RISE, slc_q.k3)
                     : over2 ? scale_rise(TON_RISE, slc_q.k2)
                     : over1 ? scale_rise(TON_RISE, slc_q.k1) : TON_RISE;
  wire [31:0] boost  = CURRENT_LIMIT_USER * ssil_q;
  wire [31:0] current_limit_w = {16'h0000, CURRENT_LIMIT_USER} + boost / `PMSEC_PCT_DIV;
  wire [15:0] current_limit_d = SOFT_START ? current_limit_w[15:0] : CURRENT_LIMIT_USER;

  // Read data: password setup and disable-once never reveal anything.
  wire [7:0] dbg_b  = DEBUG_BUF[RD_INDEX[2:0]*8 +: 8];
  wire [7:0] mask_b = mask_q[RD_INDEX*8 +: 8];
  wire [7:0] slc_b  = slc_q[RD_INDEX[2:0]*8 +: 8];
  wire [7:0] rd_d   = (cmd_q == `PMSEC_CMD_DEBUG)   ? dbg_b
                    : (cmd_q == `PMSEC_CMD_MASK)    ? mask_b
                    : (cmd_q == `PMSEC_CMD_TURNS)   ? TURNS
                    : (cmd_q == `PMSEC_CMD_OSCTRIM) ? OSC_TRIM
                    : (cmd_q == `PMSEC_CMD_SLCCFG)  ? slc_b
                    : (cmd_q == `PMSEC_CMD_SSILIM)  ? ssil_q : `PMSEC_RESET_BYTE;

  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      state_q <= PMSEC_IDLE;
      cmd_q   <= `PMSEC_RESET_BYTE;
      cnt_q   <= '0;
      buf_q   <= '0;
    end else begin
      if (CMD_VALID) begin
        cmd_q   <= CMD_CODE;
        cnt_q   <= '0;
        buf_q   <= '0;
        state_q <= (prot_hit || dis_off) ? PMSEC_DONE : PMSEC_WR;
      end else if (wr_byte) begin
        buf_q <= {buf_q[247:0], WR_BYTE};
        cnt_q <= (cnt_q == `PMSEC_LEN_MASK) ? cnt_q : cnt_q + 6'd1;
      end else if (stop_ok || (state_q == PMSEC_DONE && WR_STOP)) begin
        state_q <= PMSEC_IDLE;
      end
    end
  end

  // Refusals are reported the cycle after the command byte.
  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      CMD_NACK      <= 1'b0;
      CMD_PROTECTED <= 1'b0;
    end else begin
      CMD_NACK      <= CMD_VALID && (prot_hit || dis_off);
      CMD_PROTECTED <= CMD_VALID && prot_hit;
    end
  end

  // Suspension only clears at reset, which stands for the controller power-up.
  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      pw_q   <= `PMSEC_PW_DEFAULT;
      sec_q  <= 1'b0;
      susp_q <= 1'b0;
    end else begin
      if (pw_set) begin
        pw_q  <= pw_new;
        sec_q <= 1'b1;
      end
      if (dis_do) begin
        susp_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      mask_q   <= '0;
      TURNS    <= `PMSEC_RESET_BYTE;
      OSC_TRIM <= `PMSEC_RESET_BYTE;
      slc_q    <= '0;
      ssil_q   <= `PMSEC_RESET_BYTE;
    end else begin
      if (mask_wr) begin
        mask_q <= buf_q;
      end
      if (byte_wr && cmd_q == `PMSEC_CMD_TURNS) begin
        TURNS <= buf_q[7:0];
      end
      if (byte_wr && cmd_q == `PMSEC_CMD_OSCTRIM) begin
        OSC_TRIM <= buf_q[7:0];
      end
      if (byte_wr && cmd_q == `PMSEC_CMD_SSILIM) begin
        ssil_q <= buf_q[7:0];
      end
      if (slc_wr) begin
        slc_q <= pmsec_slc_t'(buf_q[63:0]);
      end
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      RD_BYTE       <= `PMSEC_RESET_BYTE;
      SECURITY_ON   <= 1'b0;
      RISE_TIME     <= '0;
      COEF_BANK3    <= 1'b0;
      MEAS_V_START  <= `PMSEC_RESET_BYTE;
      MEAS_V_END    <= `PMSEC_RESET_BYTE;
      CURRENT_LIMIT <= '0;
    end else begin
      RD_BYTE       <= RD_REQ ? rd_d : `PMSEC_RESET_BYTE;
      SECURITY_ON   <= sec_q && !susp_q;
      RISE_TIME     <= rise_d;
      COEF_BANK3    <= over3;
      MEAS_V_START  <= slc_q.v_start;
      MEAS_V_END    <= slc_q.v_end;
      CURRENT_LIMIT <= current_limit_d;
    end
  end

  AST_NACK_OFF: assert property (@(posedge CLOCK) disable iff (!RESET_N)
    CMD_VALID && CMD_CODE == `PMSEC_CMD_DISONCE && !sec_q |=> CMD_NACK)
    else $error("disable-once not refused while security off");
  AST_PW_ZERO: assert property (@(posedge CLOCK) disable iff (!RESET_N)
    RD_REQ && cmd_q == `PMSEC_CMD_PWSETUP |=> RD_BYTE == 8'h00)
    else $error("password read not zero");
  AST_SEC_ON: assert property (@(posedge CLOCK) disable iff (!RESET_N)
    pw_set |=> sec_q && pw_q == $past(pw_new))
    else $error("security not on after password setup");
  // SECURITY_ON lags the suspend flag by one register stage.
  AST_SUSPEND: assert property (@(posedge CLOCK) disable iff (!RESET_N)
    dis_do |=> ##1 !SECURITY_ON ##1 !SECURITY_ON)
    else $error("protection not suspended");
  AST_PROT: assert property (@(posedge CLOCK) disable iff (!RESET_N)
    CMD_VALID && sec_q && !susp_q && mask_q[CMD_CODE] |=> CMD_PROTECTED && CMD_NACK)
    else $error("masked command not protected");
  AST_UNMASK: assert property (@(posedge CLOCK) disable iff (!RESET_N)
    CMD_VALID && !mask_q[CMD_CODE] && CMD_CODE != `PMSEC_CMD_DISONCE |=> !CMD_NACK)
    else $error("unmasked command refused");
  AST_BANK3: assert property (@(posedge CLOCK) disable iff (!RESET_N)
    over3 |=> COEF_BANK3 && RISE_TIME == scale_rise($past(TON_RISE), $past(slc_q.k3)))
    else $error("bank 3 or third factor not applied");
  AST_HIGHEST: assert property (@(posedge CLOCK) disable iff (!RESET_N)
    over2 && !over3 |=> RISE_TIME == scale_rise($past(TON_RISE), $past(slc_q.k2)))
    else $error("wrong ramp factor chosen");
  AST_CURRENT_LIMIT: assert property (@(posedge CLOCK) disable iff (!RESET_N)
    !SOFT_START |=> CURRENT_LIMIT == $past(CURRENT_LIMIT_USER))
    else $error("current limit boosted outside soft start");
  AST_TURNS: assert property (@(posedge CLOCK) disable iff (!RESET_N)
    byte_wr && cmd_q == `PMSEC_CMD_TURNS |=> TURNS == $past(buf_q[7:0]))
    else $error("turn ratio not stored");

  // Storage, hold, idle, read-back, ramp-factor and soft-start checks; these guard the paths the bench reaches rarely.
  AST_MASK_STORE: assert property (@(posedge CLOCK) disable iff (!RESET_N)
    mask_wr |=> mask_q == $past(buf_q))
    else $error("protection mask not stored");
  AST_OSC: assert property (@(posedge CLOCK) disable iff (!RESET_N)
    byte_wr && cmd_q == `PMSEC_CMD_OSCTRIM |=> OSC_TRIM == $past(buf_q[7:0]))
    else $error("oscillator trim not stored");
  AST_SLC_MEAS: assert property (@(posedge CLOCK) disable iff (!RESET_N)
    slc_wr |=> ##1 {MEAS_V_END, MEAS_V_START} == $past(slc_q[15:0]))
    else $error("measurement window not applied");
  AST_SEC_OUT: assert property (@(posedge CLOCK) disable iff (!RESET_N)
    sec_q && !susp_q |=> SECURITY_ON)
    else $error("security output not raised");
  AST_SEC_HOLD: assert property (@(posedge CLOCK) disable iff (!RESET_N)
    sec_q |=> sec_q)
    else $error("security dropped without reset");
  AST_SUSP_HOLD: assert property (@(posedge CLOCK) disable iff (!RESET_N)
    susp_q |=> susp_q)
    else $error("suspension ended without reset");
  AST_NACK_PULSE: assert property (@(posedge CLOCK) disable iff (!RESET_N)
    !CMD_VALID |=> !CMD_NACK)
    else $error("refusal without a command");
  AST_PROT_NACK: assert property (@(posedge CLOCK) disable iff (!RESET_N)
    CMD_PROTECTED |-> CMD_NACK)
    else $error("protected command not refused");
  AST_RD_IDLE: assert property (@(posedge CLOCK) disable iff (!RESET_N)
    !RD_REQ |=> RD_BYTE == `PMSEC_RESET_BYTE)
    else $error("read byte not idle");
  AST_DEBUG_RD: assert property (@(posedge CLOCK) disable iff (!RESET_N)
    RD_REQ && cmd_q == `PMSEC_CMD_DEBUG |=> RD_BYTE == $past(DEBUG_BUF[RD_INDEX[2:0]*8 +: 8]))
    else $error("debug byte wrong");
  AST_DIS_RD: assert property (@(posedge CLOCK) disable iff (!RESET_N)
    RD_REQ && cmd_q == `PMSEC_CMD_DISONCE |=> RD_BYTE == `PMSEC_RESET_BYTE)
    else $error("disable-once read not zero");
  AST_OVER1: assert property (@(posedge CLOCK) disable iff (!RESET_N)
    over1 && !over2 && !over3 |=> RISE_TIME == scale_rise($past(TON_RISE), $past(slc_q.k1)))
    else $error("first ramp factor not applied");
  AST_NONE: assert property (@(posedge CLOCK) disable iff (!RESET_N)
    !over1 && !over2 && !over3 |=> RISE_TIME == $past(TON_RISE))
    else $error("rise time scaled below all limits");
  AST_NOBANK3: assert property (@(posedge CLOCK) disable iff (!RESET_N)
    !over3 |=> !COEF_BANK3)
    else $error("bank 3 chosen below third limit");
  AST_CURRENT_LIMIT_SS: assert property (@(posedge CLOCK) disable iff (!RESET_N)
    SOFT_START |=> CURRENT_LIMIT >= $past(CURRENT_LIMIT_USER))
    else $error("soft start current limit below user setting");
  AST_PW_KEEP: assert property (@(posedge CLOCK) disable iff (!RESET_N)
    stop_ok && cmd_q == `PMSEC_CMD_PWSETUP && pw_cur != pw_q |=> pw_q == $past(pw_q))
    else $error("password changed without the current password");
  AST_CMD_LATCH: assert property (@(posedge CLOCK) disable iff (!RESET_N)
    CMD_VALID |=> cmd_q == $past(CMD_CODE))
    else $error("command code not latched");

  COV_PWSET: cover property (@(posedge CLOCK) pw_set);
  COV_DISABLE: cover property (@(posedge CLOCK) dis_do);
  COV_PROT: cover property (@(posedge CLOCK) CMD_PROTECTED);
  COV_BANK3: cover property (@(posedge CLOCK) COEF_BANK3 && SOFT_START);
  COV_SUSP_WR: cover property (@(posedge CLOCK) susp_q && CMD_VALID && mask_q[CMD_CODE]);

endmodule : pmsec_bank
`default_nettype wire

// ===== design/pmsec_consts.svh
// Constants of the manufacturer security and tuning command bank.
// Assumes a PMBus transaction layer outside that frames commands into byte strings.
`ifndef PMSEC_CONSTS_SVH
`define PMSEC_CONSTS_SVH
`define PMSEC_CMD_DEBUG    8'hf0
`define PMSEC_CMD_PWSETUP  8'hf1
`define PMSEC_CMD_DISONCE  8'hf2
`define PMSEC_CMD_MASK     8'hf4
`define PMSEC_CMD_TURNS    8'hf5
`define PMSEC_CMD_OSCTRIM  8'hf6
`define PMSEC_CMD_SLCCFG   8'hf7
`define PMSEC_CMD_SSILIM   8'hf8
`define PMSEC_LEN_PWSETUP  5'd12
`define PMSEC_LEN_DISONCE  5'd6
`define PMSEC_LEN_MASK     6'd32
`define PMSEC_LEN_DEBUG    5'd8
`define PMSEC_LEN_BYTE     5'd1
`define PMSEC_LEN_SLCCFG   5'd8
`define PMSEC_PW_DEFAULT   48'h303030303030
`define PMSEC_RESET_BYTE   8'h00
`define PMSEC_PCT_DIV      16'd100
`endif

// ===== design/pmsec_pkg.sv
// Types of the manufacturer security and tuning command bank.
// Assumes nothing beyond the constants header.
package pmsec_pkg;
  typedef struct packed {
    logic [7:0] k3;
    logic [7:0] limit3;
    logic [7:0] k2;
    logic [7:0] limit2;
    logic [7:0] k1;
    logic [7:0] limit1;
    logic [7:0] v_end;
    logic [7:0] v_start;
  } pmsec_slc_t;
  typedef enum logic [1:0] {
    PMSEC_IDLE = 2'b00,
    PMSEC_WR   = 2'b01,
    PMSEC_DONE = 2'b11
  } pmsec_state_t;
endpackage : pmsec_pkg

// ===== sim/pmsec_host_model.sv
// Behavioural PMBus host that frames commands into the bank's byte stream.
// Assumes the bench calls its tasks one at a time; it drives at falling edges.
`timescale 1ns/1ps
`default_nettype none
module pmsec_host_model (
  // Clock.
  input  wire logic       clock,
  // Command stream.
  output logic            cmd_valid,
  output logic [7:0]      cmd_code,
  output logic            wr_valid,
  output logic [7:0]      wr_byte,
  output logic            wr_stop,
  output logic            rd_req,
  output logic [4:0]      rd_index,
  // Answers.
  input  wire logic [7:0] rd_byte,
  input  wire logic       cmd_nack,
  input  wire logic       cmd_prot
);
  initial begin
    {cmd_valid, wr_valid, wr_stop, rd_req} = 4'h0;
    cmd_code = 8'h00;
    wr_byte = 8'h00;
    rd_index = 5'h00;
  end
  // Idle lines show the inverse of the last value so stale data never looks valid.
  task automatic open(input logic [7:0] code);
    @(negedge clock);
    cmd_valid = 1'b1;
    cmd_code = code;
    @(negedge clock);
    cmd_valid = 1'b0;
    cmd_code = ~code;
  endtask : open
  task automatic xfer(input logic [7:0] code, input int n, input logic [255:0] d,
                      output logic nk, output logic pr);
    open(code);
    nk = cmd_nack;
    pr = cmd_prot;
    // Bank 3 coefficients live outside this bank.
    for (int i = n - 1; i >= 0; i--) begin
      wr_valid = 1'b1;
      wr_byte = d[8*i+:8];
      @(negedge clock);
    end
    wr_valid = 1'b0;
    wr_byte = ~wr_byte;
    wr_stop = 1'b1;
    @(negedge clock);
    wr_stop = 1'b0;
  endtask : xfer
  task automatic rd(input logic [7:0] code, input logic [4:0] idx, output logic [7:0] b);
    open(code);
    rd_req = 1'b1;
    rd_index = idx;
    @(negedge clock);
    rd_req = 1'b0;
    rd_index = ~idx;
    b = rd_byte;
  endtask : rd
endmodule : pmsec_host_model
`default_nettype wire

// ===== sim/tb.sv
// Self-checking bench for the security and tuning command bank.
// Assumes the host model drives the command stream; converter inputs come from here.
`include "pmsec_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module tb;
  import pmsec_pkg::*;
  logic        CLOCK, RESET_N, CMD_VALID, WR_VALID, WR_STOP, RD_REQ, CMD_NACK;
  logic        CMD_PROTECTED, CAP_VALID, SOFT_START, SECURITY_ON, COEF_BANK3, nk, pr;
  logic [7:0]  CMD_CODE, WR_BYTE, RD_BYTE, CAP_ESTIMATE, TURNS, OSC_TRIM, b;
  logic [7:0]  MEAS_V_START, MEAS_V_END;
  logic [4:0]  RD_INDEX;
  logic [63:0] DEBUG_BUF;
  logic [15:0] TON_RISE, CURRENT_LIMIT_USER, RISE_TIME, CURRENT_LIMIT;
  pmsec_slc_t  cfg;
  int          n_mismatch, n_checks;
  pmsec_bank pmsec_bank_inst (.CLOCK(CLOCK), .RESET_N(RESET_N), .CMD_VALID(CMD_VALID),
    .CMD_CODE(CMD_CODE), .WR_VALID(WR_VALID), .WR_BYTE(WR_BYTE), .WR_STOP(WR_STOP),
    .RD_REQ(RD_REQ), .RD_INDEX(RD_INDEX), .RD_BYTE(RD_BYTE), .CMD_NACK(CMD_NACK),
    .CMD_PROTECTED(CMD_PROTECTED), .DEBUG_BUF(DEBUG_BUF), .CAP_ESTIMATE(CAP_ESTIMATE),
    .CAP_VALID(CAP_VALID), .TON_RISE(TON_RISE), .CURRENT_LIMIT_USER(CURRENT_LIMIT_USER),
    .SOFT_START(SOFT_START), .SECURITY_ON(SECURITY_ON), .TURNS(TURNS),
    .OSC_TRIM(OSC_TRIM), .RISE_TIME(RISE_TIME), .COEF_BANK3(COEF_BANK3),
    .MEAS_V_START(MEAS_V_START), .MEAS_V_END(MEAS_V_END), .CURRENT_LIMIT(CURRENT_LIMIT));
  pmsec_host_model pmsec_host_model_inst (.clock(CLOCK), .cmd_valid(CMD_VALID),
    .cmd_code(CMD_CODE), .wr_valid(WR_VALID), .wr_byte(WR_BYTE), .wr_stop(WR_STOP),
    .rd_req(RD_REQ), .rd_index(RD_INDEX), .rd_byte(RD_BYTE), .cmd_nack(CMD_NACK),
    .cmd_prot(CMD_PROTECTED));
  task automatic chk(input logic [63:0] s, input logic [63:0] e);
    n_checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("[FAIL] %0t ns: saw %0h, expected %0h", $time, s, e);
    end
  endtask : chk
  task automatic close_out();
    $display("checks %0d, mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : close_out
  initial begin
    CLOCK = 1'b0;
    forever #2 CLOCK = ~CLOCK;
  end
  initial begin
    #40000;
    n_mismatch++;
    close_out();
  end
  // Security off at start, so disable-once must be refused.
  task automatic t_off();
    chk(SECURITY_ON, 1'b0);
    pmsec_host_model_inst.xfer(`PMSEC_CMD_DISONCE, 6, `PMSEC_PW_DEFAULT, nk, pr);
    chk(nk, 1'b1);
  endtask : t_off
  task automatic t_tune();
    pmsec_host_model_inst.xfer(`PMSEC_CMD_TURNS, 1, 8'ha5, nk, pr);
    chk(TURNS, 8'ha5);
    pmsec_host_model_inst.rd(`PMSEC_CMD_TURNS, 5'h00, b);
    chk(b, 8'ha5);
    pmsec_host_model_inst.xfer(`PMSEC_CMD_OSCTRIM, 1, 8'h3c, nk, pr);
    chk(OSC_TRIM, 8'h3c);
  endtask : t_tune
  // Mask the turn-ratio command, then arm security with a new password.
  task automatic t_secure();
    pmsec_host_model_inst.xfer(`PMSEC_CMD_MASK, 32, 256'h1 << 8'hf5, nk, pr);
    pmsec_host_model_inst.rd(`PMSEC_CMD_MASK, 5'h1e, b);
    chk(b, 8'h20);
    pmsec_host_model_inst.xfer(`PMSEC_CMD_PWSETUP, 12,
                               {`PMSEC_PW_DEFAULT, 48'h414243444546}, nk, pr);
    @(negedge CLOCK);
    chk(SECURITY_ON, 1'b1);
    pmsec_host_model_inst.rd(`PMSEC_CMD_PWSETUP, 5'h00, b);
    chk(b, 8'h00);
    pmsec_host_model_inst.xfer(`PMSEC_CMD_TURNS, 1, 8'h5a, nk, pr);
    chk(pr, 1'b1);
    chk(nk, 1'b1);
    chk(TURNS, 8'ha5);
    pmsec_host_model_inst.xfer(`PMSEC_CMD_OSCTRIM, 1, 8'hc3, nk, pr);
    chk(nk, 1'b0);
    chk(OSC_TRIM, 8'hc3);
    pmsec_host_model_inst.xfer(`PMSEC_CMD_DISONCE, 6, `PMSEC_PW_DEFAULT, nk, pr);
    @(negedge CLOCK);
    chk(SECURITY_ON, 1'b1);
    pmsec_host_model_inst.xfer(`PMSEC_CMD_DISONCE, 6, 48'h414243444546, nk, pr);
    @(negedge CLOCK);
    chk(SECURITY_ON, 1'b0);
    pmsec_host_model_inst.xfer(`PMSEC_CMD_TURNS, 1, 8'h5a, nk, pr);
    chk(TURNS, 8'h5a);
  endtask : t_secure
  task automatic t_slc();
    cfg = '{8'h80, 8'h20, 8'h10, 8'h10, 8'h10, 8'h08, 8'h60, 8'h10};
    pmsec_host_model_inst.xfer(`PMSEC_CMD_SLCCFG, 8, cfg, nk, pr);
    @(negedge CLOCK);
    chk({MEAS_V_END, MEAS_V_START}, 16'h6010);
    CAP_ESTIMATE = 8'h30;
    CAP_VALID = 1'b1;
    repeat (3) @(negedge CLOCK);
    chk(COEF_BANK3, 1'b1);
    chk(RISE_TIME, 16'h0000);
    CAP_ESTIMATE = 8'h18;
    repeat (3) @(negedge CLOCK);
    chk(COEF_BANK3, 1'b0);
    chk(RISE_TIME, 16'h0400);
    CAP_ESTIMATE = 8'h0c;
    repeat (3) @(negedge CLOCK);
    chk(RISE_TIME, 16'h0400);
    CAP_VALID = 1'b0;
    repeat (3) @(negedge CLOCK);
    chk(RISE_TIME, 16'h0040);
  endtask : t_slc
  task automatic t_misc();
    CURRENT_LIMIT_USER = 16'h00c8;
    pmsec_host_model_inst.xfer(`PMSEC_CMD_SSILIM, 1, 8'h32, nk, pr);
    SOFT_START = 1'b1;
    repeat (3) @(negedge CLOCK);
    chk(CURRENT_LIMIT, 16'h012c);
    SOFT_START = 1'b0;
    repeat (3) @(negedge CLOCK);
    chk(CURRENT_LIMIT, 16'h00c8);
    DEBUG_BUF = 64'h0123456789abcdef;
    pmsec_host_model_inst.rd(`PMSEC_CMD_DEBUG, 5'h03, b);
    chk(b, 8'h89);
  endtask : t_misc
  initial begin
    {RESET_N, CAP_VALID, SOFT_START} = 3'h0;
    CAP_ESTIMATE = 8'h00;
    DEBUG_BUF = 64'h0;
    TON_RISE = 16'h0040;
    CURRENT_LIMIT_USER = 16'h0000;
    repeat (10) @(negedge CLOCK);
    RESET_N = 1'b1;
    t_off();
    t_tune();
    t_secure();
    t_slc();
    t_misc();
    close_out();
  end
endmodule : tb
`default_nettype wire
